// >>> rtl/swp_defines.svh
`ifndef SWP_DEFINES_SVH
`define SWP_DEFINES_SVH
`define SWP_POL_MSB 15
`define SWP_POL_LSB 12
`define SWP_KEY_MSB 11
`define SWP_KEY_LSB 8
`define SWP_SECRET_BIT 7
`define SWP_BIT_MAC 3
`define SWP_BIT_ENC 2
`define SWP_BIT_DRV 1
`define SWP_BIT_SRC 0
`define SWP_OTP_MODE_RO 8'hAA
`define SWP_OTP_MODE_CONS 8'h55
`define SWP_OTP_MODE_LEG 8'h00
`define SWP_UNLOCKED 8'h55
`define SWP_OTP_RESET 32'hFFFFFFFF
`define SWP_A_CTRL 12'h000
`define SWP_A_SLOTCFG 12'h004
`define SWP_A_CMD 12'h008
`define SWP_A_STATUS 12'h00C
`define SWP_A_DATA 12'h010
`define SWP_A_RDDATA 12'h014
`define SWP_A_ID 12'h018
`define SWP_A_REV 12'h01C
`define SWP_A_OTP 12'h100
`define SWP_ID_FIXED 24'h5A5A5A
`define SWP_ID_DIE 48'h123456789ABC
`define SWP_REV_VALUE 32'h00000001
`endif

// >>> rtl/swp_pkg.sv
package swp_pkg;
   typedef enum logic [2:0] {
      SWP_OP_READ = 3'h0, SWP_OP_WRITE = 3'h1, SWP_OP_DERIVE = 3'h2, SWP_OP_HASH = 3'h3
   } swp_op_t;
   typedef enum logic [2:0] {
      SWP_ST_IDLE = 3'b001, SWP_ST_EVAL = 3'b010, SWP_ST_DONE = 3'b100
   } swp_state_t;
endpackage : swp_pkg

// >>> rtl/swp_policy_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "swp_defines.svh"
module swp_policy_decode (
   input wire logic [3:0] policy,
   output logic derive_ok,
   output logic derive_parent,
   output logic derive_mac,
   output logic write_clear,
   output logic write_enc,
   output logic write_never
);
   // The two decodes look at the same field independently.
   assign derive_ok = policy[`SWP_BIT_DRV];
   assign derive_parent = policy[`SWP_BIT_SRC];
   assign derive_mac = policy[`SWP_BIT_MAC];
   assign write_clear = (policy[3:1] == 3'h0);
   assign write_enc = policy[`SWP_BIT_ENC];
   assign write_never = !policy[`SWP_BIT_ENC] && (policy[3] || policy[1]);
endmodule : swp_policy_decode
`default_nettype wire

// >>> rtl/swp_access_ctrl.sv
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "swp_defines.svh"
module swp_access_ctrl
   import swp_pkg::*;
#(
   parameter int OTP_WORDS = 16
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [71:0] hash_id_bytes,
   output logic hash_id_valid
);
   ////////////////////////////////////////////////////////////////////////////
   // State.
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] cfg_lock;
      logic [7:0] data_lock;
      logic [7:0] otp_mode;
      logic [15:0] slot_cfg;
      logic [3:0] slot_idx;
      logic [3:0] key_slot_cfg;
      logic [31:0] cmd;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [3:0] status;
      logic [71:0] hash_id;
      logic hash_valid;
      swp_state_t state;
   } swp_regs_t;

   swp_regs_t cur_ff;
   swp_regs_t nxt_ff;
   logic [31:0] otp_mem_ff [OTP_WORDS];
   logic otp_we;
   logic [3:0] otp_widx;
   logic [31:0] otp_wval;

   logic derive_ok, derive_parent, derive_mac, write_clear, write_enc, write_never;

   swp_policy_decode u_dec (
      .policy(cur_ff.slot_cfg[`SWP_POL_MSB:`SWP_POL_LSB]),
      .derive_ok(derive_ok),
      .derive_parent(derive_parent),
      .derive_mac(derive_mac),
      .write_clear(write_clear),
      .write_enc(write_enc),
      .write_never(write_never)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Command fields: op[2:0], len32[3], mac_ok[4], enc[5], mac_cur_key[6],
   // include_die[7], zone_otp[8], word[19:16].
   swp_op_t op;
   logic len32, mac_ok, enc, mac_cur, inc_die, zone_otp;
   logic [3:0] word;
   logic cfg_locked, data_locked, secret;
   logic otp_word_ok;
   assign op = swp_op_t'(cur_ff.cmd[2:0]);
   assign len32 = cur_ff.cmd[3];
   assign mac_ok = cur_ff.cmd[4];
   assign enc = cur_ff.cmd[5];
   assign mac_cur = cur_ff.cmd[6];
   assign inc_die = cur_ff.cmd[7];
   assign zone_otp = cur_ff.cmd[8];
   assign word = cur_ff.cmd[19:16];
   assign cfg_locked = (cur_ff.cfg_lock != `SWP_UNLOCKED);
   assign data_locked = (cur_ff.data_lock != `SWP_UNLOCKED);
   assign secret = cur_ff.slot_cfg[`SWP_SECRET_BIT];
   assign otp_word_ok = ({28'h0, word} < OTP_WORDS);

   logic apb_wr, apb_rd;
   assign apb_wr = psel && penable && pwrite && !cur_ff.pready;
   assign apb_rd = psel && penable && !pwrite && !cur_ff.pready;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   logic ok;
   logic [3:0] src;
   logic [31:0] otp_rd;
   always_comb begin
      nxt_ff = cur_ff;
      ok = 1'b0;
      src = 4'h0;
      otp_we = 1'b0;
      otp_widx = word;
      otp_wval = cur_ff.wdata;
      otp_rd = otp_mem_ff[word];
      nxt_ff.pready = 1'b0;
      nxt_ff.pslverr = 1'b0;
      nxt_ff.hash_valid = 1'b0;
      if (apb_wr) begin
         nxt_ff.pready = 1'b1;
         case (paddr)
            `SWP_A_CTRL: begin
               // Locks only move from unlocked to locked.
               if (!cfg_locked) nxt_ff.cfg_lock = pwdata[7:0];
               if (!data_locked) nxt_ff.data_lock = pwdata[15:8];
               if (!cfg_locked) nxt_ff.otp_mode = pwdata[23:16];
            end
            `SWP_A_SLOTCFG: begin
               nxt_ff.slot_cfg = pwdata[15:0];
               nxt_ff.slot_idx = pwdata[19:16];
               nxt_ff.key_slot_cfg = pwdata[23:20];
            end
            `SWP_A_CMD: begin
               nxt_ff.cmd = pwdata;
               nxt_ff.state = SWP_ST_EVAL;
            end
            `SWP_A_DATA: nxt_ff.wdata = pwdata;
            `SWP_A_ID, `SWP_A_REV: nxt_ff.pslverr = 1'b1;
            default: nxt_ff.pslverr = 1'b1;
         endcase
      end else if (apb_rd) begin
         nxt_ff.pready = 1'b1;
         case (paddr)
            `SWP_A_CTRL: nxt_ff.prdata = {8'h00, cur_ff.otp_mode, cur_ff.data_lock,
                                          cur_ff.cfg_lock};
            `SWP_A_SLOTCFG: nxt_ff.prdata = {8'h00, cur_ff.key_slot_cfg, cur_ff.slot_idx,
                                             cur_ff.slot_cfg};
            `SWP_A_CMD: nxt_ff.prdata = cur_ff.cmd;
            `SWP_A_STATUS: nxt_ff.prdata = {28'h0, cur_ff.status};
            `SWP_A_DATA: nxt_ff.prdata = cur_ff.wdata;
            `SWP_A_RDDATA: nxt_ff.prdata = cur_ff.rdata;
            `SWP_A_ID: nxt_ff.prdata = {8'h00, `SWP_ID_FIXED};
            `SWP_A_REV: nxt_ff.prdata = `SWP_REV_VALUE;
            default: begin
               nxt_ff.prdata = 32'h0;
               nxt_ff.pslverr = 1'b1;
            end
         endcase
      end

      case (cur_ff.state)
         SWP_ST_IDLE: ;
         SWP_ST_EVAL: begin
            nxt_ff.state = SWP_ST_DONE;
            case (op)
               SWP_OP_DERIVE: begin
                  ok = derive_ok && (!derive_mac || mac_ok);
                  src = derive_parent ? cur_ff.slot_cfg[`SWP_KEY_MSB:`SWP_KEY_LSB]
                                      : cur_ff.slot_idx;
               end
               SWP_OP_HASH: begin
                  ok = 1'b1;
                  nxt_ff.hash_id = {`SWP_ID_FIXED, inc_die ? `SWP_ID_DIE : 48'h0};
                  nxt_ff.hash_valid = 1'b1;
               end
               SWP_OP_WRITE: begin
                  if (zone_otp) begin
                     if (!cfg_locked || !otp_word_ok) ok = 1'b0;
                     else if (!data_locked) ok = 1'b1;
                     else if (cur_ff.otp_mode == `SWP_OTP_MODE_CONS) begin
                        ok = 1'b1;
                        otp_wval = cur_ff.wdata & otp_rd;
                     end else ok = 1'b0;
                     otp_we = ok;
                  end else if (!data_locked) ok = cfg_locked;
                  else if (secret && !len32) ok = 1'b0;
                  else if (write_clear) ok = !enc;
                  else if (write_never) ok = 1'b0;
                  else if (write_enc) begin
                     ok = len32 && enc && mac_ok;
                     if (cur_ff.slot_cfg[`SWP_KEY_MSB:`SWP_KEY_LSB] == cur_ff.slot_idx)
                        ok = ok && mac_cur;
                  end
               end
               default: begin
                  if (zone_otp) begin
                     if (!cfg_locked || !data_locked || !otp_word_ok) ok = 1'b0;
                     else if (cur_ff.otp_mode == `SWP_OTP_MODE_LEG)
                        ok = !len32 && (word > 4'h1);
                     else ok = 1'b1;
                     nxt_ff.rdata = ok ? otp_rd : 32'h0;
                  end else ok = cfg_locked && data_locked && !(secret && !len32);
               end
            endcase
            nxt_ff.status = {src[2:0] & {3{op == SWP_OP_DERIVE}}, ok};
         end
         SWP_ST_DONE: nxt_ff.state = SWP_ST_IDLE;
         default: nxt_ff.state = SWP_ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cur_ff <= '0;
         cur_ff.cfg_lock <= `SWP_UNLOCKED;
         cur_ff.data_lock <= `SWP_UNLOCKED;
         cur_ff.state <= SWP_ST_IDLE;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // The OTP array is refilled erased (all ones) on every reset_n assertion, not only at power-up.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < OTP_WORDS; i++) otp_mem_ff[i] <= `SWP_OTP_RESET;
      end else if (otp_we) begin
         otp_mem_ff[otp_widx] <= otp_wval;
      end
   end

   assign prdata = cur_ff.prdata;
   assign pready = cur_ff.pready;
   assign pslverr = cur_ff.pslverr;
   assign hash_id_bytes = cur_ff.hash_id;
   assign hash_id_valid = cur_ff.hash_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Checks and cover points.
   chk_derive_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_DERIVE && !derive_ok
      |=> !cur_ff.status[0]) else $error("derive accepted without bit 13");
   chk_derive_mac: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_DERIVE && derive_mac && !mac_ok
      |=> !cur_ff.status[0]) else $error("derive accepted without mac");
   chk_never_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_WRITE && !zone_otp && data_locked
      && write_never |=> !cur_ff.status[0]) else $error("never slot written");
   chk_secret_short: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && !zone_otp && data_locked && secret && !len32
      && (op == SWP_OP_WRITE || op == SWP_OP_READ) |=> !cur_ff.status[0])
      else $error("short access to secret slot");
   chk_otp_prelock: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && zone_otp && !cfg_locked
      && (op == SWP_OP_WRITE || op == SWP_OP_READ) |=> !cur_ff.status[0])
      else $error("otp reached before config lock");
   chk_consume_and: assert property (@(posedge core_clk) disable iff (!reset_n)
      otp_we && data_locked |=> (otp_mem_ff[$past(otp_widx)] & ~$past(otp_rd)) == 32'h0)
      else $error("otp bit rose in consumption");
   chk_legacy_read: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_READ && zone_otp
      && cur_ff.otp_mode == `SWP_OTP_MODE_LEG && (word < 4'h2 || len32)
      |=> !cur_ff.status[0]) else $error("legacy read allowed");
   chk_id_readonly: assert property (@(posedge core_clk) disable iff (!reset_n)
      apb_wr && paddr == `SWP_A_ID |=> pready && pslverr)
      else $error("identity write not refused");
   chk_fixed_hash: assert property (@(posedge core_clk) disable iff (!reset_n)
      hash_id_valid |-> hash_id_bytes[71:48] == `SWP_ID_FIXED)
      else $error("fixed serial missing in hash");
   cov_derive: cover property (@(posedge core_clk) cur_ff.state == SWP_ST_EVAL
      && op == SWP_OP_DERIVE && derive_ok);
   cov_enc_write: cover property (@(posedge core_clk) cur_ff.state == SWP_ST_EVAL
      && op == SWP_OP_WRITE && write_enc);
   cov_consume: cover property (@(posedge core_clk) otp_we && data_locked);
   cov_legacy_read: cover property (@(posedge core_clk) cur_ff.state == SWP_ST_EVAL
      && op == SWP_OP_READ && zone_otp && cur_ff.otp_mode == `SWP_OTP_MODE_LEG);
   cov_hash_die: cover property (@(posedge core_clk) cur_ff.state == SWP_ST_EVAL
      && op == SWP_OP_HASH && inc_die);
   chk_roll_source: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_DERIVE && !derive_parent
      |=> cur_ff.status[3:1] == $past(cur_ff.slot_idx[2:0]))
      else $error("roll derivation used wrong source");
   chk_clear_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_WRITE && !zone_otp && data_locked
      && write_clear && !secret && !enc |=> cur_ff.status[0])
      else $error("clear write refused");
   chk_enc_short: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_WRITE && !zone_otp && data_locked
      && write_enc && !len32 |=> !cur_ff.status[0])
      else $error("short write to encrypt slot");
   chk_self_key: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_WRITE && !zone_otp && data_locked
      && write_enc && cur_ff.slot_cfg[`SWP_KEY_MSB:`SWP_KEY_LSB] == cur_ff.slot_idx
      && !mac_cur |=> !cur_ff.status[0]) else $error("self-keyed write without current key");
   chk_ro_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_WRITE && zone_otp && data_locked
      && cur_ff.otp_mode == `SWP_OTP_MODE_RO |=> !cur_ff.status[0])
      else $error("read-only otp written");
   chk_legacy_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_WRITE && zone_otp && data_locked
      && cur_ff.otp_mode == `SWP_OTP_MODE_LEG |=> !cur_ff.status[0])
      else $error("legacy otp written");
   chk_unlock_read: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_READ && zone_otp && !data_locked
      |=> !cur_ff.status[0]) else $error("otp read before data lock");
   chk_legacy_long: assert property (@(posedge core_clk) disable iff (!reset_n)
      cur_ff.state == SWP_ST_EVAL && op == SWP_OP_READ && zone_otp
      && cur_ff.otp_mode == `SWP_OTP_MODE_LEG && len32 |=> !cur_ff.status[0])
      else $error("legacy long read allowed");
   chk_die_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      hash_id_valid && !inc_die |-> hash_id_bytes[47:0] == 48'h0)
      else $error("die bytes hashed unasked");
   chk_otp_locked: assert property (@(posedge core_clk) disable iff (!reset_n)
      otp_we |-> cfg_locked) else $error("otp written before config lock");
   chk_ready_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
      pready |=> !pready) else $error("ready held longer than one cycle");
endmodule : swp_access_ctrl
`default_nettype wire

// >>> testbench/swp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module swp_host_model (
   input wire logic core_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [71:0] hash_id_bytes,
   input wire logic hash_id_valid
);
   logic [71:0] hash_last;
   logic hung;
   initial begin
      hung = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'hFFF;
      pwdata = 32'h0;
      hash_last = 72'h0;
   end
   // Released lines carry the inverse of the last value, so stale data cannot match.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      hung = (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
   ////////////////////////////////////////
   // Keeps the last serial value handed to a hash.
   always @(posedge core_clk) begin
      if (hash_id_valid === 1'b1) begin
         hash_last <= hash_id_bytes;
      end
   end
endmodule : swp_host_model
`default_nettype wire

// >>> testbench/slot_write_policy_otp_access_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "swp_defines.svh"
module slot_write_policy_otp_access_test;
   import swp_pkg::*;
   logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, hash_id_valid, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [71:0] hash_id_bytes;
   logic [2:0] src_roll, src_make;
   int n_errors, tests_run;
   swp_access_ctrl #(.OTP_WORDS(16)) swp_access_ctrl_i (.core_clk(core_clk),
      .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hash_id_bytes(hash_id_bytes), .hash_id_valid(hash_id_valid));
   swp_host_model swp_host_model_i (.core_clk(core_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hash_id_bytes(hash_id_bytes), .hash_id_valid(hash_id_valid));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   ////////////////////////////////////////
   task automatic conclude;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      swp_host_model_i.xfer(w, a, d, rdata, rerr);
      if (swp_host_model_i.hung) begin
         n_errors++;
         $display("MISMATCH t=%0t no ready on bus", $time);
      end
   endtask : bus
   // Flags: 01 len32, 02 mac, 04 enc, 08 current key, 10 die bytes, 20 OTP zone.
   function automatic logic [31:0] cw(input logic [2:0] op, input logic [5:0] f,
         input logic [3:0] w);
      return {12'h000, w, 7'h00, f, op};
   endfunction : cw
   task automatic cmd(input logic [31:0] c, input logic ok);
      bus(1'b1, `SWP_A_CMD, c);
      repeat (2) @(posedge core_clk);
      bus(1'b0, `SWP_A_STATUS, 32'h0);
      chk({31'h0, rdata[0]}, {31'h0, ok});
   endtask : cmd
   task automatic otp_rd(input logic [3:0] w, input logic [31:0] exp);
      cmd(cw(SWP_OP_READ, 6'h20, w), 1'b1);
      bus(1'b0, `SWP_A_RDDATA, 32'h0);
      chk(rdata, exp);
   endtask : otp_rd
   task automatic ctrl(input logic [23:0] v);
      bus(1'b1, `SWP_A_CTRL, {8'h00, v});
      bus(1'b0, `SWP_A_CTRL, 32'h0);
      chk(rdata, {8'h00, v});
   endtask : ctrl
   task automatic restart;
      reset_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
   endtask : restart
   task automatic slot(input logic [15:0] cfg);
      bus(1'b1, `SWP_A_SLOTCFG, {12'h000, 4'h3, cfg});
   endtask : slot
   task automatic hchk(input logic die);
      logic [47:0] d;
      d = die ? `SWP_ID_DIE : 48'h0;
      cmd(cw(SWP_OP_HASH, die ? 6'h10 : 6'h00, 4'h0), 1'b1);
      chk({8'h00, swp_host_model_i.hash_last[71:48]}, {8'h00, `SWP_ID_FIXED});
      chk({16'h0000, swp_host_model_i.hash_last[47:32]}, {16'h0000, d[47:32]});
      chk(swp_host_model_i.hash_last[31:0], d[31:0]);
   endtask : hchk
   ////////////////////////////////////////
   initial begin
      #2000000;
      n_errors++;
      conclude();
   end
   initial begin
      reset_n = 1'b0;
      n_errors = 0;
      tests_run = 0;
      restart();
      bus(1'b0, `SWP_A_ID, 32'h0);
      chk({8'h00, rdata[23:0]}, {8'h00, `SWP_ID_FIXED});
      bus(1'b1, `SWP_A_ID, 32'hFFFFFFFF);
      chk({31'h0, rerr}, 32'h1);
      bus(1'b0, `SWP_A_REV, 32'h0);
      chk(rdata, `SWP_REV_VALUE);
      bus(1'b1, `SWP_A_REV, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      bus(1'b0, 12'h020, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      cmd(cw(SWP_OP_READ, 6'h20, 4'h2), 1'b0);
      cmd(cw(SWP_OP_WRITE, 6'h20, 4'h2), 1'b0);
      ctrl(24'h555555);
      ctrl(24'h555500);
      cmd(cw(SWP_OP_READ, 6'h20, 4'h3), 1'b0);
      bus(1'b1, `SWP_A_DATA, 32'hF0F0F0F0);
      cmd(cw(SWP_OP_WRITE, 6'h20, 4'h3), 1'b1);
      bus(1'b1, `SWP_A_DATA, 32'hFFFFFFFF);
      cmd(cw(SWP_OP_WRITE, 6'h26, 4'hF), 1'b1);
      ctrl(24'h550000);
      otp_rd(4'h0, 32'hFFFFFFFF);
      otp_rd(4'h3, 32'hF0F0F0F0);
      bus(1'b1, `SWP_A_DATA, 32'h0FF0FF00);
      cmd(cw(SWP_OP_WRITE, 6'h20, 4'h3), 1'b1);
      otp_rd(4'h3, 32'h00F0F000);
      restart();
      ctrl(24'hAA5555);
      ctrl(24'hAA5500);
      ctrl(24'hAA0000);
      bus(1'b1, `SWP_A_DATA, 32'h0);
      cmd(cw(SWP_OP_WRITE, 6'h20, 4'h1), 1'b0);
      otp_rd(4'h1, 32'hFFFFFFFF);
      cmd(cw(SWP_OP_READ, 6'h21, 4'h0), 1'b1);
      restart();
      ctrl(24'h005555);
      ctrl(24'h005500);
      ctrl(24'h000000);
      cmd(cw(SWP_OP_READ, 6'h20, 4'h0), 1'b0);
      cmd(cw(SWP_OP_READ, 6'h20, 4'h1), 1'b0);
      otp_rd(4'hF, 32'hFFFFFFFF);
      cmd(cw(SWP_OP_READ, 6'h21, 4'h2), 1'b0);
      cmd(cw(SWP_OP_WRITE, 6'h20, 4'h2), 1'b0);
      otp_rd(4'h2, 32'hFFFFFFFF);
      for (int p = 0; p < 16; p++) begin
         slot({p[3:0], 4'h5, p[3:1] != 3'b000, 7'h00});
         cmd(cw(SWP_OP_DERIVE, 6'h00, 4'h0), p[1] & ~p[3]);
         cmd(cw(SWP_OP_DERIVE, 6'h02, 4'h0), p[1]);
         if (p == 2) src_roll = rdata[3:1];
         if (p == 3) src_make = rdata[3:1];
         cmd(cw(SWP_OP_WRITE, 6'h01, 4'h0), p[3:1] == 3'b000);
         cmd(cw(SWP_OP_WRITE, 6'h00, 4'h0), p[3:1] == 3'b000);
         cmd(cw(SWP_OP_WRITE, 6'h0F, 4'h0), p[2]);
         cmd(cw(SWP_OP_WRITE, 6'h0E, 4'h0), 1'b0);
      end
      chk({29'h0, src_roll}, 32'h3);
      chk({29'h0, src_make}, 32'h5);
      slot(16'h0380);
      cmd(cw(SWP_OP_READ, 6'h00, 4'h0), 1'b0);
      cmd(cw(SWP_OP_WRITE, 6'h00, 4'h0), 1'b0);
      slot(16'h0300);
      cmd(cw(SWP_OP_READ, 6'h00, 4'h0), 1'b1);
      slot(16'h4380);
      cmd(cw(SWP_OP_WRITE, 6'h07, 4'h0), 1'b0);
      slot(16'h4580);
      cmd(cw(SWP_OP_WRITE, 6'h07, 4'h0), 1'b1);
      hchk(1'b0);
      hchk(1'b1);
      conclude();
   end
endmodule : slot_write_policy_otp_access_test
`default_nettype wire
